/* File: logic/sbt_fsm.sv */
// sixteen-state test controller, steps on each sampled tck rise
// assumes tck_rise is one cycle wide, tms already synchronised
`timescale 1ns/10ps
`default_nettype none
module sbt_fsm
  import sbt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic tck_rise,
  input wire logic tms,
  output var sbt_pkg::sbt_state_t state
);
  sbt_state_t next_state;
  always_comb begin
    case (state)
      SBT_RESET: next_state = tms ? SBT_RESET : SBT_IDLE;
      SBT_IDLE: next_state = tms ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_DR: next_state = tms ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_CAP_DR: next_state = tms ? SBT_EX1_DR : SBT_SH_DR;
      SBT_SH_DR: next_state = tms ? SBT_EX1_DR : SBT_SH_DR;
      SBT_EX1_DR: next_state = tms ? SBT_UP_DR : SBT_PA_DR;
      SBT_PA_DR: next_state = tms ? SBT_EX2_DR : SBT_PA_DR;
      SBT_EX2_DR: next_state = tms ? SBT_UP_DR : SBT_SH_DR;
      SBT_UP_DR: next_state = tms ? SBT_SEL_DR : SBT_IDLE;
      SBT_SEL_IR: next_state = tms ? SBT_RESET : SBT_CAP_IR;
      SBT_CAP_IR: next_state = tms ? SBT_EX1_IR : SBT_SH_IR;
      SBT_SH_IR: next_state = tms ? SBT_EX1_IR : SBT_SH_IR;
      SBT_EX1_IR: next_state = tms ? SBT_UP_IR : SBT_PA_IR;
      SBT_PA_IR: next_state = tms ? SBT_EX2_IR : SBT_PA_IR;
      SBT_EX2_IR: next_state = tms ? SBT_UP_IR : SBT_SH_IR;
      SBT_UP_IR: next_state = tms ? SBT_SEL_DR : SBT_IDLE;
      default: next_state = SBT_RESET;
    endcase
  end
  // five tms-high rises reach reset from any state [RL6]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SBT_RESET;
    end else if (tck_rise) begin
      state <= next_state; // [RL23]
    end
  end
endmodule
`default_nettype wire

/* File: logic/sbt_params.svh */
// constants of the boundary-scan test port
// assumes inclusion by bare name from package and modules
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_IR_W 3
`define SBT_BSR_W 75
`define SBT_ID_W 32
`define SBT_IR_CAPT 3'h1
`define SBT_OP_EXTEST 3'h0
`define SBT_OP_IDCODE 3'h1
`define SBT_OP_SAMPZ 3'h2
`define SBT_OP_SAMPLE 3'h4
`define SBT_OP_BYPASS 3'h7
`define SBT_RESET_ONES 3'h5
`define SBT_ID_VALUE 32'h1234_5679
`endif

/* File: logic/sbt_pkg.sv */
// types of the boundary-scan test port
// assumes sbt_params.svh on the include path
`include "sbt_params.svh"
package sbt_pkg;
  typedef enum logic [15:0] {
    SBT_RESET = 16'h0001, SBT_IDLE = 16'h0002, SBT_SEL_DR = 16'h0004, SBT_CAP_DR = 16'h0008,
    SBT_SH_DR = 16'h0010, SBT_EX1_DR = 16'h0020, SBT_PA_DR = 16'h0040, SBT_EX2_DR = 16'h0080,
    SBT_UP_DR = 16'h0100, SBT_SEL_IR = 16'h0200, SBT_CAP_IR = 16'h0400, SBT_SH_IR = 16'h0800,
    SBT_EX1_IR = 16'h1000, SBT_PA_IR = 16'h2000, SBT_EX2_IR = 16'h4000, SBT_UP_IR = 16'h8000
  } sbt_state_t;
  typedef enum logic [1:0] {SBT_SEL_BYP = 2'h0, SBT_SEL_ID = 2'h1, SBT_SEL_BSR = 2'h2} sbt_path_t;
endpackage

/* File: logic/sbt_sync.sv */
// two-flop synchroniser for a pin level
// assumes the pin is asynchronous to clock
`timescale 1ns/10ps
`default_nettype none
module sbt_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin,
  output logic level
);
  logic first;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first <= INIT;
      level <= INIT;
    end else begin
      first <= pin;
      level <= first;
    end
  end
endmodule
`default_nettype wire

/* File: logic/sbt_tap.sv */
// boundary-scan test port of a synchronous memory
// assumes tck, tms, tdi come from pins; io_ring from memory pins
// Functional notes
// RL1 - sample on tck rise, outputs change on fall
// RL2 - tms and tdi read high when open
// RL3 - data enters msb, leaves lsb
// RL4 - tdo driven only in shift states
// RL5 - power-up reset leaves tdo off
// RL6 - five tms-high rises reset controller
// RL7 - instruction selects exactly one register
// RL8 - three-bit instruction, idcode after reset
// RL9 - instruction capture loads 01
// RL10 - bypass bit cleared under bypass
// RL11 - boundary register 75 cells
// RL12 - capture loads pins, shift connects it
// RL13 - id capture loads hardwired 32-bit code
// RL14 - instruction takes effect at update
// RL15 - all-zero code samples, outputs off
// RL16 - sample-z samples, outputs off
// RL17 - sample captures pin snapshot
// RL18 - update under sample acts like pause
// RL19 - bypass bit is path under bypass
// RL20 - controller never loads reserved codes; update_ir loads any shifted code into instr, reserved ones too
// RL21 - never drives memory, no preload
// RL22 - codes 000, 001, 010 are extest, idcode, sample-z
// RL23 - standard sixteen-state controller
// RL24 - bypass 111, sample 100
// RL25 - reserved codes select bypass
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_tap
  import sbt_pkg::*;
#(
  parameter int BSR_W = `SBT_BSR_W,
  parameter logic [`SBT_ID_W-1:0] ID_VALUE = `SBT_ID_VALUE // arbitrary value
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // memory side
  input wire logic [BSR_W-1:0] io_ring,
  output logic mem_out_disable,
  output logic [`SBT_IR_W-1:0] instr
);
  import sbt_pkg::*;

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d;
  logic tck_rise;
  logic tck_fall;
  sbt_state_t state;
  logic [`SBT_IR_W-1:0] ir_shift;
  logic bypass_bit;
  logic [`SBT_ID_W-1:0] id_shift;
  logic [BSR_W-1:0] bsr;
  wire logic [BSR_W-1:0] io_s2;
  logic next_tdo;
  logic next_tdo_oe;
  sbt_path_t path;
  logic sel_byp;
  logic sel_id;
  logic sel_bsr;
  logic capture_dr;
  logic shift_dr;
  logic capture_ir;
  logic shift_ir;
  logic update_ir;
  logic to_reset;

  // pins default high when open, as with the pull-ups [RL2]
  // tck rests low, so no false edge after reset
  sbt_sync #(
    .INIT(1'b0)
  ) u_tck (
    .clock(clock),
    .resetn(resetn),
    .pin(tck),
    .level(tck_s)
  );
  sbt_sync #(
    .INIT(1'b1)
  ) u_tms (
    .clock(clock),
    .resetn(resetn),
    .pin(tms),
    .level(tms_s)
  );
  sbt_sync #(
    .INIT(1'b1)
  ) u_tdi (
    .clock(clock),
    .resetn(resetn),
    .pin(tdi),
    .level(tdi_s)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_d; // [RL1]
  assign tck_fall = ~tck_s & tck_d;

  sbt_fsm u_fsm (
    .clock(clock),
    .resetn(resetn),
    .tck_rise(tck_rise),
    .tms(tms_s),
    .state(state)
  );

  // controller states decoded once, qualified by the tck rise
  assign capture_dr = tck_rise && (state == SBT_CAP_DR);
  assign shift_dr = tck_rise && (state == SBT_SH_DR);
  assign capture_ir = tck_rise && (state == SBT_CAP_IR);
  assign shift_ir = tck_rise && (state == SBT_SH_IR);
  assign update_ir = tck_rise && (state == SBT_UP_IR);
  // entering reset loads idcode at once, not one rise later [RL6] [RL8]
  assign to_reset = tck_rise && ((state == SBT_RESET) || (tms_s && (state == SBT_SEL_IR)));

  // io ring is asynchronous to clock; two flops per pin before capture
  for (genvar g = 0; g < BSR_W; g++) begin : g_io_sync
    sbt_sync #(
      .INIT(1'b0)
    ) u_io (
      .clock(clock),
      .resetn(resetn),
      .pin(io_ring[g]),
      .level(io_s2[g])
    );
  end

  function automatic sbt_path_t decode(input logic [`SBT_IR_W-1:0] op);
    case (op)
      `SBT_OP_EXTEST: decode = SBT_SEL_BSR; // [RL15] [RL22]
      `SBT_OP_IDCODE: decode = SBT_SEL_ID; // [RL13] [RL22]
      `SBT_OP_SAMPZ: decode = SBT_SEL_BSR; // [RL16] [RL22]
      `SBT_OP_SAMPLE: decode = SBT_SEL_BSR; // [RL17] [RL24]
      `SBT_OP_BYPASS: decode = SBT_SEL_BYP; // [RL19] [RL24]
      default: decode = SBT_SEL_BYP; // [RL25]
    endcase
  endfunction

  function automatic logic outs_off(input logic [`SBT_IR_W-1:0] op);
    case (op)
      `SBT_OP_EXTEST: outs_off = 1'b1; // [RL15]
      `SBT_OP_SAMPZ: outs_off = 1'b1; // [RL16]
      default: outs_off = 1'b0; // [RL21]
    endcase
  endfunction

  assign path = decode(instr); // [RL7]
  assign sel_byp = (path == SBT_SEL_BYP);
  assign sel_id = (path == SBT_SEL_ID);
  assign sel_bsr = (path == SBT_SEL_BSR);

  // instruction shift and capture
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ir_shift <= '0;
    end else if (capture_ir) begin
      ir_shift <= `SBT_IR_CAPT; // [RL9]
    end else if (shift_ir) begin
      ir_shift <= {tdi_s, ir_shift[`SBT_IR_W-1:1]}; // [RL3]
    end
  end

  // active instruction changes only at update or reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      instr <= `SBT_OP_IDCODE; // [RL5] [RL8]
    end else if (to_reset) begin
      instr <= `SBT_OP_IDCODE; // [RL8]
    end else if (update_ir) begin
      instr <= ir_shift; // [RL14]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_out_disable <= 1'b0;
    end else begin
      mem_out_disable <= outs_off(instr); // [RL15] [RL16] [RL21]
    end
  end

  // bypass bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bypass_bit <= 1'b0;
    end else if (sel_byp && capture_dr) begin
      bypass_bit <= 1'b0; // [RL10]
    end else if (sel_byp && shift_dr) begin
      bypass_bit <= tdi_s; // [RL19]
    end
  end

  // identification register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      id_shift <= '0;
    end else if (sel_id && capture_dr) begin
      id_shift <= ID_VALUE; // [RL13]
    end else if (sel_id && shift_dr) begin
      id_shift <= {tdi_s, id_shift[`SBT_ID_W-1:1]}; // [RL3]
    end
  end

  // boundary register; update does nothing, no preload path [RL18] [RL21]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bsr <= '0;
    end else if (sel_bsr && capture_dr) begin
      bsr <= io_s2; // [RL11] [RL12] [RL17]
    end else if (sel_bsr && shift_dr) begin
      bsr <= {tdi_s, bsr[BSR_W-1:1]}; // [RL3] [RL12]
    end
  end

  always_comb begin
    if (state == SBT_SH_IR) begin
      next_tdo = ir_shift[0];
    end else begin
      case (path)
        SBT_SEL_ID: next_tdo = id_shift[0];
        SBT_SEL_BSR: next_tdo = bsr[0];
        default: next_tdo = bypass_bit;
      endcase
    end
  end

  // enable only in the two shift states [RL4]
  assign next_tdo_oe = (state == SBT_SH_DR) || (state == SBT_SH_IR);

  // tdo changes on tck fall [RL1]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tdo <= 1'b0;
    end else if (tck_fall) begin
      tdo <= next_tdo;
    end
  end

  // enable changes on tck fall too, off from power-up [RL1] [RL5]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= next_tdo_oe; // [RL4]
    end
  end
endmodule
`default_nettype wire

/* File: tb/sbt_ctl_model.sv */
// boundary-scan controller model driving the port pins
// assumes tdo_pin resolved by the bench, z when released
`timescale 1ns/10ps
`default_nettype none
module sbt_ctl_model (
  // system
  input wire logic clock,
  // port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_pin
);
  // idle lines rest at pull-up level, tck still
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 8-clock tck period, tdo read late in the high phase
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clock);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clock);
    tck <= 1'b1;
    repeat (3) @(posedge clock);
    q = tdo_pin;
  endtask
  // from idle: to shift, n bits lsb first, update, idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    // let instr and the disable flag settle before the caller looks
    repeat (2) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* File: tb/sbt_tap_assertions.sv */
// pin-level checker for the test port
// assumes bind from the bench top
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module sbt_tap_checker #(
  parameter int BSR_W = `SBT_BSR_W
) (
  // system
  input wire logic clock,
  input wire logic resetn,
  // port pins and memory side
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BSR_W-1:0] io_ring,
  input wire logic mem_out_disable,
  input wire logic [`SBT_IR_W-1:0] instr
);
  logic tck_q;
  logic tms_rise;
  logic tms_prior;
  logic [2:0] ones;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // tms seen at the last two tck rises, run of tms-high rises
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tck_q <= 1'b0;
      tms_rise <= 1'b1;
      tms_prior <= 1'b1;
      ones <= 3'h0;
    end else begin
      tck_q <= tck;
      if (tck && !tck_q) begin
        tms_rise <= tms;
        tms_prior <= tms_rise;
        ones <= tms ? ones + 3'h1 : 3'h0;
      end
    end
  end
  a_reset_vals: assert property ($rose(resetn) |-> instr == 3'h1 && !tdo_oe && !mem_out_disable)
    else $error("bad values after reset");
  a_oe_quiet: assert property ($rose(resetn) |-> !tdo_oe [*8])
    else $error("tdo driven after reset");
  a_out_timing: assert property ($changed(tdo) || $changed(tdo_oe) |-> !$past(tck, 3) && $past(tck, 4))
    else $error("tdo moved off a tck fall");
  a_hold_high: assert property (tck && $past(tck) |-> $stable(tdo) && $stable(tdo_oe))
    else $error("tdo moved while tck high");
  a_instr_change: assert property ($changed(instr) |-> tms_prior)
    else $error("instr moved outside update");
  a_tms_reset: assert property (tck && !tck_q && tms && ones == 3'h4 |-> ##[1:20] instr == 3'h1)
    else $error("no reset after five tms rises");
  a_outdis_on: assert property ($stable(instr) && (instr == 3'h0 || instr == 3'h2) |-> ##[0:1] mem_out_disable)
    else $error("outputs not disabled");
  a_outdis_off: assert property ($stable(instr) && !(instr == 3'h0 || instr == 3'h2) |-> ##[0:1] !mem_out_disable)
    else $error("outputs disabled wrongly");
  cover property ($rose(tdo_oe));
  cover property ($rose(mem_out_disable));
  cover property (instr == 3'h7);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// bench: every instruction code, scan paths, tms reset
// assumes checker and controller model under tb/
`timescale 1ns/10ps
`default_nettype none
`include "sbt_params.svh"
module testbench;
  import sbt_pkg::*;
  localparam logic [127:0] pat = 128'hC3A5_96F0_1E2D_4B78_E1D2;
  logic clock, resetn, tck, tms, tdi, tdo, tdo_oe, tdo_pin, mem_out_disable, q;
  logic [`SBT_BSR_W-1:0] io_ring;
  logic [`SBT_IR_W-1:0] instr;
  logic [127:0] dout, exp_v;
  int fail_count, cmp_count, len;
  assign tdo_pin = tdo_oe ? tdo : 1'bz;
  sbt_tap sbt_tap_inst (.clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .io_ring(io_ring), .mem_out_disable(mem_out_disable), .instr(instr));
  sbt_ctl_model sbt_ctl_model_inst (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin));
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("%0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic test_codes();
    for (int c = 0; c < 8; c++) begin
      io_ring <= ~io_ring;
      sbt_ctl_model_inst.scan(1'b1, 3, 128'(c), dout);
      check(dout[2:0], 3'h1);
      check(instr, c[2:0]);
      check(mem_out_disable, c == 0 || c == 2);
      sbt_ctl_model_inst.scan(1'b0, 80, pat, dout);
      len = c == 1 ? 32 : (c == 0 || c == 2 || c == 4) ? 75 : 1;
      exp_v = pat << len;
      if (len == 75) exp_v = exp_v | 128'(io_ring);
      if (len == 32) exp_v = exp_v | 128'(`SBT_ID_VALUE);
      check(dout[79:0], exp_v[79:0]);
    end
    $display("test_codes done");
  endtask
  task automatic test_tms_reset();
    // from shift-dr all five tms-high rises are needed
    sbt_ctl_model_inst.step(1'b1, 1'b1, q);
    sbt_ctl_model_inst.step(1'b0, 1'b1, q);
    sbt_ctl_model_inst.step(1'b0, 1'b1, q);
    for (int i = 0; i < 5; i++) begin
      sbt_ctl_model_inst.step(1'b1, 1'b1, q);
      @(posedge clock);
      if (i == 3) check(instr, 3'h7);
    end
    check(instr, 3'h1);
    sbt_ctl_model_inst.step(1'b0, 1'b1, q);
    check(tdo_oe, 1'b0);
    $display("test_tms_reset done");
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    io_ring = {3{25'h15A5C3F}};
    fail_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (8) @(posedge clock);
    check({instr, tdo_oe, mem_out_disable}, 5'h4);
    sbt_ctl_model_inst.step(1'b0, 1'b1, q);
    test_codes();
    test_tms_reset();
    end_of_test();
  end
endmodule
bind sbt_tap sbt_tap_checker #(.BSR_W(BSR_W)) sbt_tap_checker_inst (.clock(clock), .resetn(resetn),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .io_ring(io_ring),
  .mem_out_disable(mem_out_disable), .instr(instr));
`default_nettype wire
